// ---- hdl/bit_word_pkg.sv ----
// constants for the built-in-test status word block
package bit_word_pkg;

    // ------------------------------------------------------------
    // test word field positions
    // ------------------------------------------------------------
    localparam int FATAL_BIT    = 0;
    localparam int HW_FLT_BIT   = 1;
    localparam int LINK_FLT_BIT = 2;
    localparam int SW_FLT_BIT   = 3;
    localparam int SUMMARY_BIT  = 8;
    localparam int HW_ALR_BIT   = 9;
    localparam int LINK_ALR_BIT = 10;
    localparam int ALGO_ALR_BIT = 11;
    localparam int OVR_ALR_BIT  = 12;
    localparam int WORD_W       = 16;
    localparam int WORD_BYTES   = 2;

    // ------------------------------------------------------------
    // alert enable positions and reset value (hw alert off)
    // ------------------------------------------------------------
    localparam int EN_HW   = 0;
    localparam int EN_SW   = 1;
    localparam int EN_SENS = 2;
    localparam int EN_LINK = 3;
    localparam logic [3:0] ALERT_EN_RST = 4'he;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ       = 40000000;
    localparam longint INIT_TIME_S  = 60;
    localparam longint INIT_CYCLES  = INIT_TIME_S * CLK_HZ;
    localparam int     TURN_MDPS    = 500;  // turn threshold, mdeg/s

    // packet rates selectable in Hz; 7 selects polled (quiet) mode
    localparam int RATE_W = 3;
    localparam logic [RATE_W-1:0] RATE_QUIET = 3'h7;

    function automatic longint rate_period(input logic [RATE_W-1:0] sel);
        case (sel)
            3'h0:    rate_period = CLK_HZ / 100;
            3'h1:    rate_period = CLK_HZ / 50;
            3'h2:    rate_period = CLK_HZ / 25;
            3'h3:    rate_period = CLK_HZ / 20;
            3'h4:    rate_period = CLK_HZ / 10;
            3'h5:    rate_period = CLK_HZ / 5;
            default: rate_period = CLK_HZ / 2;
        endcase
    endfunction : rate_period

endpackage : bit_word_pkg

// ---- hdl/snap_if.sv ----
// interface carrying one status snapshot between modules
`timescale 1ns/10ps
`default_nettype none
interface snap_if;
    logic        take;
    logic [15:0] word;
    modport src (output word, input take);
    modport dst (input word, output take);
endinterface : snap_if
`default_nettype wire

// ---- hdl/bit_word_build.sv ----
// combinational assembly of the built-in-test word
`timescale 1ns/10ps
`default_nettype none
module bit_word_build
    import bit_word_pkg::*;
(
    // fault inputs
    input  wire logic fatal_in,
    input  wire logic hw_fault_in,
    input  wire logic link_fault_in,
    input  wire logic sw_fault_in,
    input  wire logic mag_align_bad,
    input  wire logic mag_uncal,
    // alert inputs
    input  wire logic hw_alert_in,
    input  wire logic gps_link_lost,
    input  wire logic algo_active,
    input  wire logic turn_active,
    input  wire logic turn_alert_en,
    input  wire logic overrange_in,
    input  wire logic [3:0] alert_en,
    // assembled word
    snap_if.src  snap
);
    logic hw_a;
    logic sw_a;
    logic ovr_a;
    logic lnk_a;

    always_comb begin
        hw_a  = hw_alert_in & alert_en[EN_HW];
        lnk_a = gps_link_lost & alert_en[EN_LINK];
        sw_a  = (algo_active | (turn_alert_en & turn_active))
                & alert_en[EN_SW];
        ovr_a = overrange_in & alert_en[EN_SENS];
        snap.word = '0;
        snap.word[FATAL_BIT]    = fatal_in;
        snap.word[HW_FLT_BIT]   = hw_fault_in;
        snap.word[LINK_FLT_BIT] = link_fault_in;
        snap.word[SW_FLT_BIT]   = sw_fault_in | mag_align_bad
                                  | mag_uncal;
        snap.word[HW_ALR_BIT]   = hw_a;
        snap.word[LINK_ALR_BIT] = lnk_a;
        snap.word[ALGO_ALR_BIT] = sw_a;
        snap.word[OVR_ALR_BIT]  = ovr_a;
        snap.word[SUMMARY_BIT]  = hw_a | lnk_a | sw_a | ovr_a;
    end
endmodule : bit_word_build
`default_nettype wire

// ---- hdl/pkt_timer.sv ----
// periodic packet tick generator for the selectable rates
`timescale 1ns/10ps
`default_nettype none
module pkt_timer
    import bit_word_pkg::*;
#(
    // divides every packet period; 1 gives the true rates
    parameter longint RATE_DIV = 1
)(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // rate select
    input  wire logic [RATE_W-1:0] rate_sel,
    // tick out
    output logic                   tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic [31:0] limit;

    always_comb begin
        limit   = 32'(rate_period(rate_sel) / RATE_DIV - 1);
        tick    = 1'b0;
        cnt_nxt = cnt_r + 32'h1;
        if (rate_sel == RATE_QUIET) begin
            cnt_nxt = '0;
        end else if (cnt_r >= limit) begin
            cnt_nxt = '0;
            tick    = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : pkt_timer
`default_nettype wire

// ---- hdl/bit_status_word.sv ----
// built-in-test word generator with packet scheduling and diag requests
`timescale 1ns/10ps
`default_nettype none
module bit_status_word
    import bit_word_pkg::*;
#(
    parameter longint INIT_CYC = INIT_CYCLES,
    // divides every packet period; 1 gives the true rates
    parameter longint RATE_DIV = 1
)(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // fault sources (asynchronous)
    input  wire logic              fatal_in,
    input  wire logic              hw_fault_in,
    input  wire logic              link_fault_in,
    input  wire logic              sw_fault_in,
    input  wire logic              mag_align_bad,
    input  wire logic              mag_uncal,
    // alert sources (asynchronous)
    input  wire logic              hw_alert_in,
    input  wire logic              gps_link_lost,
    input  wire logic              high_gain,
    input  wire logic              turn_active,
    input  wire logic              overrange_in,
    // configuration
    input  wire logic [3:0]        alert_en,
    input  wire logic              turn_alert_en,
    input  wire logic [RATE_W-1:0] rate_sel,
    // host requests
    input  wire logic              get_packet_cmd,
    input  wire logic              diag_req,
    // packet output
    output logic                   meas_valid,
    output logic [WORD_W-1:0]      bit_word,
    output logic                   diag_packet,
    output logic                   init_busy
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 11;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    assign raw = {fatal_in, hw_fault_in, link_fault_in, sw_fault_in,
                  mag_align_bad, mag_uncal, hw_alert_in, gps_link_lost,
                  high_gain, turn_active, overrange_in};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    // ------------------------------------------------------------
    // start-up initialisation timer
    // ------------------------------------------------------------
    logic [31:0] init_cnt_r;
    logic [31:0] init_cnt_nxt;
    logic        init_r;
    logic        init_nxt;

    always_comb begin
        init_cnt_nxt = init_cnt_r;
        init_nxt     = init_r;
        if (init_r) begin
            if (init_cnt_r >= 32'(INIT_CYC - 1)) begin
                init_nxt = 1'b0;
            end else begin
                init_cnt_nxt = init_cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            init_cnt_r <= '0;
            init_r     <= 1'b1;
        end else begin
            init_cnt_r <= init_cnt_nxt;
            init_r     <= init_nxt;
        end
    end

    assign init_busy = init_r;

    // ------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------
    snap_if snap ();
    logic algo_active;
    assign algo_active = init_r | s2_r[2];

    bit_word_build u_build (
        .fatal_in      (s2_r[10]),
        .hw_fault_in   (s2_r[9]),
        .link_fault_in (s2_r[8]),
        .sw_fault_in   (s2_r[7]),
        .mag_align_bad (s2_r[6]),
        .mag_uncal     (s2_r[5]),
        .hw_alert_in   (s2_r[4]),
        .gps_link_lost (s2_r[3]),
        .algo_active   (algo_active),
        .turn_active   (s2_r[1]),
        .turn_alert_en (turn_alert_en),
        .overrange_in  (s2_r[0]),
        .alert_en      (alert_en),
        .snap          (snap)
    );

    // ------------------------------------------------------------
    // packet scheduling
    // ------------------------------------------------------------
    logic tick;
    pkt_timer #(.RATE_DIV(RATE_DIV)) u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .rate_sel (rate_sel),
        .tick     (tick)
    );

    logic              cmd_d_r;
    logic              diag_d_r;
    logic              meas_r;
    logic              meas_nxt;
    logic              diag_r;
    logic              diag_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;

    assign snap.take = meas_nxt;

    always_comb begin
        meas_nxt = tick | (get_packet_cmd & ~cmd_d_r);
        diag_nxt = diag_req & ~diag_d_r;
        word_nxt = word_r;
        if (snap.take) begin
            word_nxt = snap.word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_d_r  <= 1'b0;
            diag_d_r <= 1'b0;
            meas_r   <= 1'b0;
            diag_r   <= 1'b0;
            word_r   <= '0;
        end else begin
            cmd_d_r  <= get_packet_cmd;
            diag_d_r <= diag_req;
            meas_r   <= meas_nxt;
            diag_r   <= diag_nxt;
            word_r   <= word_nxt;
        end
    end

    assign meas_valid  = meas_r;
    assign bit_word    = word_r;
    assign diag_packet = diag_r;
endmodule : bit_status_word
`default_nettype wire

// ---- bench/bit_status_word_properties.sv ----
// checker for the built-in-test word generator ports
`timescale 1ns/10ps
`default_nettype none
module bit_status_word_properties
    import bit_word_pkg::*;
#(
    parameter longint INIT_CYC = 50
)(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              rst,
    // watched ports
    input wire logic [3:0]        alert_en,
    input wire logic [RATE_W-1:0] rate_sel,
    input wire logic              get_packet_cmd,
    input wire logic              diag_req,
    input wire logic              meas_valid,
    input wire logic [WORD_W-1:0] bit_word,
    input wire logic              diag_packet,
    input wire logic              init_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_reserved_bits_zero: assert property (bit_word[7:4] == 4'h0 && bit_word[15:13] == 3'h0)
        else $error("reserved word bits set");
    a_summary_is_or: assert property (bit_word[8] == (|bit_word[12:9]))
        else $error("summary alert differs from alert or");
    a_word_held: assert property (!meas_valid |-> $stable(bit_word))
        else $error("word changed between packets");
    a_cmd_answered: assert property ($rose(get_packet_cmd) |=> meas_valid)
        else $error("poll not answered next cycle");
    a_quiet_single_packet: assert property (meas_valid && rate_sel == RATE_QUIET
        |=> !meas_valid [*2])
        else $error("extra packet in polled mode");
    a_diag_answered: assert property ($rose(diag_req) |=> diag_packet)
        else $error("diagnostic request not answered");
    a_diag_has_cause: assert property (diag_packet |-> $past(diag_req) && !$past(diag_req, 2))
        else $error("diagnostic packet without request edge");
    a_hw_alert_off: assert property (meas_valid && !$past(alert_en[EN_HW])
        |-> !bit_word[HW_ALR_BIT])
        else $error("disabled hardware alert shown");
    a_init_algo_alert: assert property (meas_valid && init_busy && $past(init_busy)
        && $past(init_busy, 2) && $past(alert_en[EN_SW]) |-> bit_word[ALGO_ALR_BIT])
        else $error("algorithm alert low during start-up");
endmodule : bit_status_word_properties

bind bit_status_word bit_status_word_properties #(.INIT_CYC(INIT_CYC)) props_inst (
    .sys_clk, .rst, .alert_en, .rate_sel, .get_packet_cmd, .diag_req,
    .meas_valid, .bit_word, .diag_packet, .init_busy
);
`default_nettype wire

// ---- bench/host_model.sv ----
// host model: polls measurement and diagnostic packets
`timescale 1ns/10ps
`default_nettype none
module host_model
    import bit_word_pkg::*;
(
    // clock
    input  wire logic              sys_clk,
    // requests to the device
    output logic                   get_packet_cmd,
    output logic                   diag_req,
    // answers from the device
    input  wire logic              meas_valid,
    input  wire logic [WORD_W-1:0] bit_word,
    input  wire logic              diag_packet
);
    initial begin
        get_packet_cmd = 1'b0;
        diag_req       = 1'b0;
    end

    // idle gap, raise request, hold to the answer edge, release
    task automatic request(input bit diag, input int gap,
                           output logic [WORD_W-1:0] w);
        w = 'x;
        repeat (gap + 1) @(negedge sys_clk);
        if (diag) diag_req = 1'b1;
        else get_packet_cmd = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            #1;
            if (diag ? diag_packet : meas_valid) begin
                w = bit_word;
                break;
            end
        end
        @(negedge sys_clk);
        diag_req = 1'b0;
        get_packet_cmd = 1'b0;
    endtask : request
endmodule : host_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the built-in-test word generator
`timescale 1ns/10ps
`default_nettype none
module testbench
    import bit_word_pkg::*;
;
    localparam longint INIT_CYC = 50;
    localparam longint RATE_DIV  = 2000;
    localparam int     PER       = int'(CLK_HZ / 100 / RATE_DIV);
    localparam int     PERIOD_NS = 25;
    logic              sys_clk;
    logic              rst;
    logic [10:0]       src;
    logic [3:0]        alert_en;
    logic              turn_alert_en;
    logic [RATE_W-1:0] rate_sel;
    logic              get_packet_cmd;
    logic              diag_req;
    logic              meas_valid;
    logic [WORD_W-1:0] bit_word;
    logic              diag_packet;
    logic              init_busy;
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] e;
    time               t_rel;
    int                n_errors;
    int                checks;

    bit_status_word #(.INIT_CYC(INIT_CYC), .RATE_DIV(RATE_DIV))
        bit_status_word_inst (
        .sys_clk, .rst, .fatal_in(src[0]), .hw_fault_in(src[1]),
        .link_fault_in(src[2]), .sw_fault_in(src[3]),
        .mag_align_bad(src[4]), .mag_uncal(src[5]), .hw_alert_in(src[6]),
        .gps_link_lost(src[7]), .high_gain(src[8]), .turn_active(src[9]),
        .overrange_in(src[10]), .alert_en, .turn_alert_en, .rate_sel,
        .get_packet_cmd, .diag_req, .meas_valid, .bit_word, .diag_packet,
        .init_busy
    );
    host_model host_inst (
        .sys_clk, .get_packet_cmd, .diag_req, .meas_valid, .bit_word,
        .diag_packet
    );

    // ------------------------------------------------------------
    // expectation, comparison and closing
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_word(input logic [10:0] s,
        input logic [3:0] en, input logic ten, input logic init);
        logic [15:0] e;
        e = 16'h0000;
        e[3:0] = {|s[5:3], s[2:0]};
        e[9] = s[6] & en[0];
        e[10] = s[7] & en[3];
        e[11] = (init | s[8] | (s[9] & ten)) & en[1];
        e[12] = s[10] & en[2];
        e[8] = |e[12:9];
        return e;
    endfunction : exp_word

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic poll(input bit diag, input int gap, input logic [15:0] exp);
        host_inst.request(diag, gap, w);
        // an unanswered request leaves w unknown and counts a mismatch
        if (diag) begin
            check(16'(!$isunknown(w)), 16'h0001);
        end else begin
            check(w, exp);
        end
    endtask : poll

    // ------------------------------------------------------------
    // clock and sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        n_errors = 0;
        checks = 0;
        rst = 1'b1;
        src = 11'h000;
        alert_en = ALERT_EN_RST;
        turn_alert_en = 1'b0;
        rate_sel = RATE_QUIET;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_rel = $time;
        check(16'(init_busy), 16'h0001);
        e = exp_word(src, alert_en, 1'b0, 1'b1);
        poll(1'b0, 4, e);
        // start-up phase lasts exactly INIT_CYC cycles after release
        for (int i = 0; i < 2 * INIT_CYC && init_busy; i++) begin
            @(negedge sys_clk);
        end
        check(16'(($time - t_rel) / PERIOD_NS), 16'(INIT_CYC));
        check(16'(init_busy), 16'h0000);
        poll(1'b1, 1, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            src = 11'h001 << i;
            e = exp_word(src, alert_en, 1'b0, 1'b0);
            poll(1'b0, 4, e);
        end
        for (int k = 0; k < 3; k++) begin
            alert_en = (k == 0) ? 4'hf : (k == 1) ? 4'he : 4'h0;
            turn_alert_en = (k != 1);
            for (int i = 6; i < 12; i++) begin
                src = (i == 11) ? 11'h7ff : 11'h001 << i;
                e = exp_word(src, alert_en, turn_alert_en, 1'b0);
                poll(1'b0, 4 + k, e);
            end
        end
        // fixed-rate mode: spacing of ticks and word contents
        alert_en = 4'hf;
        rate_sel = 3'h0;
        for (int n = 0; n < 2; n++) begin
            t_rel = $time;
            @(negedge sys_clk);
            for (int i = 0; i < 2 * PER && !meas_valid; i++) begin
                @(negedge sys_clk);
            end
            check(16'(($time - t_rel) / PERIOD_NS), 16'(PER));
            e = exp_word(src, alert_en, turn_alert_en, 1'b0);
            check(bit_word, e);
        end
        rate_sel = RATE_QUIET;
        // mid-run reset: outputs clear and start-up phase restarts
        alert_en = ALERT_EN_RST;
        rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(bit_word, 16'h0000);
        check(16'({meas_valid, diag_packet, init_busy}), 16'h0001);
        rst = 1'b0;
        e = exp_word(src, alert_en, turn_alert_en, 1'b1);
        poll(1'b0, 1, e);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
